/* File: common/tpc_pkg.sv */
// Purpose: Shared constants for the thermal pin configuration bank.
// Assumes: Eight-bit register addresses and eight-bit register data.
// Notes:   Every offset, field position and reset value lives here.
package tpc_pkg;

    // ************************************************************
    // Register offsets
    // ************************************************************
    localparam logic [7:0] TPC_ADDR_FMT_CFG = 8'h7c;
    localparam logic [7:0] TPC_ADDR_PIN_CFG = 8'h7d;
    localparam logic [7:0] TPC_ADDR_TEST_A  = 8'h7e;
    localparam logic [7:0] TPC_ADDR_TEST_B  = 8'h7f;

    // ************************************************************
    // Reset values and writable bit masks
    // ************************************************************
    localparam logic [7:0] TPC_RST_FMT_CFG  = 8'h00;
    localparam logic [7:0] TPC_RST_PIN_CFG  = 8'h00;
    localparam logic [7:0] TPC_TEST_VALUE   = 8'h00;
    localparam logic [7:0] TPC_MASK_FMT_CFG = 8'hef;
    localparam logic [7:0] TPC_MASK_PIN_CFG = 8'h4f;
    localparam logic [7:0] TPC_READ_UNMAP   = 8'h00;

    // ************************************************************
    // Field positions
    // ************************************************************
    localparam int TPC_BIT_SIGNED_FMT   = 0;
    localparam int TPC_BIT_EN_LO        = 5;
    localparam int TPC_BIT_EN_HI        = 7;
    localparam int TPC_BIT_FUNC_LO      = 0;
    localparam int TPC_BIT_FUNC_HI      = 1;
    localparam int TPC_BIT_ALARM_DIS    = 2;
    localparam int TPC_BIT_SPEED_SEL    = 3;
    localparam int TPC_BIT_ATTEN_BYPASS = 6;

    // ************************************************************
    // Shared pin function codes and limit codes
    // ************************************************************
    typedef enum logic [1:0] {
        TPC_FUNC_FAN4_TACH_INPUT = 2'h0,
        TPC_FUNC_ALARM = 2'h1,
        TPC_FUNC_ALERT = 2'h2,
        TPC_FUNC_GPIO  = 2'h3
    } tpc_func_t;

    // Minus 64 degrees in offset-64 code, minus 128 in signed code.
    localparam logic [7:0] TPC_LIM_OFF_OFF64  = 8'h00;
    localparam logic [7:0] TPC_LIM_OFF_SIGNED = 8'h80;
    localparam logic [7:0] TPC_DUTY_FULL      = 8'hff;
    localparam logic [7:0] TPC_SIGN_FLIP      = 8'h80;

endpackage

/* File: hw/tpc_limit_cmp.sv */
// Purpose: Compares one temperature channel against its alarm limit.
// Assumes: Temperature and limit share one coding, chosen by fmt_signed.
// Notes:   Purely combinational; the caller registers the result.
`timescale 1ns/1ps
module tpc_limit_cmp
    import tpc_pkg::*;
(
    // Coding select
    input  wire logic       fmt_signed,
    // Channel values
    input  wire logic [7:0] temp,
    input  wire logic [7:0] limit,
    // Result
    output logic            over,
    output logic            limit_off
);

    // ************************************************************
    // Comparison
    // ************************************************************

    // Signed codes get their sign flipped so an unsigned compare works.
    wire logic [7:0] temp_key;
    wire logic [7:0] limit_key;
    wire logic [7:0] off_code;

    assign temp_key  = fmt_signed ? (temp ^ TPC_SIGN_FLIP) : temp;
    assign limit_key = fmt_signed ? (limit ^ TPC_SIGN_FLIP) : limit;

    assign off_code  = fmt_signed ? TPC_LIM_OFF_SIGNED : TPC_LIM_OFF_OFF64;
    assign limit_off = (limit == off_code);

    // A limit at the lowest code turns the channel off, never on.
    assign over = !limit_off && (temp_key > limit_key);

endmodule

/* File: hw/tpc_config_regs.sv */
// Purpose: Pin and alarm configuration bank with its alarm pin logic.
// Assumes: A serial engine on ref_clk presents decoded register accesses.
// Notes:   Limits, temperatures and maximum duties come from other banks.
//
// Behaviour
// - Local enable bit 6 lets the local limit drive the alarm pin.
// - Remote-2 enable bit 7 lets the remote-2 limit drive the pin.
// - Offset-64 limit of minus 64 degrees turns that channel's alarm off.
// - Signed limit of minus 128 degrees turns that channel's alarm off.
// - With the lock input high, writes to both registers are ignored.
// - Two-bit field picks shared pin role: fan4_tach_input, alarm, alert, GPIO.
// - Alarm disable bit 2 turns the whole alarm feature off.
// - Speed select 0 sends all fans to full speed on alarm.
// - Speed select 1 sends fans to their programmed maximum duty.
// - Bypass bit 6 switches core voltage channel to the unattenuated scale.
// - Both test registers read zero and ignore writes.
// - Format bit 0 selects signed or offset-64 temperature coding.
// - Remote-1 enable bit 5 lets the remote-1 limit drive the pin.
`timescale 1ns/1ps
module tpc_config_regs
    import tpc_pkg::*;
#(
    parameter int NCH  = 3,
    parameter int NFAN = 3
)
(
    // Clock and reset
    input  wire logic                 ref_clk,
    input  wire logic                 rst,
    // Register access from the serial engine
    input  wire logic [7:0]           reg_addr,
    input  wire logic [7:0]           reg_wdata,
    input  wire logic                 reg_wr,
    input  wire logic                 reg_rd,
    output logic [7:0]                reg_rdata,
    // Lock bit held in another configuration register
    input  wire logic                 cfg_lock,
    // Channel temperatures and limits: remote1, local, remote2
    input  wire logic [NCH-1:0][7:0]  chan_temp,
    input  wire logic [NCH-1:0][7:0]  chan_limit,
    // Maximum duties held elsewhere
    input  wire logic [NFAN-1:0][7:0] fan_max_duty,
    // Thermal alarm pin, open drain, active low on the wire
    input  wire logic                 thermal_alarm_pin_in,
    output logic                      thermal_alarm_pin_out,
    output logic                      thermal_alarm_pin_oe,
    output logic                      alarm_timer_in,
    // Shared pin alarm drive and role
    output logic                      shared_pin_out,
    output logic                      shared_pin_oe,
    output logic [3:0]                shared_pin_role,
    // Fan override
    output logic                      fan_override,
    output logic [NFAN-1:0][7:0]      fan_override_duty,
    // Settings used by other blocks
    output logic                      signed_temperature_format,
    output logic                      core_voltage_attenuator_bypass
);

    // ************************************************************
    // Registers
    // ************************************************************
    logic [7:0]           fmt_cfg_r;
    logic [7:0]           pin_cfg_r;
    logic [7:0]           rdata_r;
    logic                 alarm_r;
    logic                 fan_ovr_r;
    logic [NFAN-1:0][7:0] duty_r;
    logic                 pin_meta_r;
    logic                 pin_sync_r;

    // ************************************************************
    // Write decode
    // ************************************************************
    wire logic       wr_ok;
    wire logic       wr_fmt;
    wire logic       wr_pin;
    wire logic [7:0] fmt_cfg_nxt;
    wire logic [7:0] pin_cfg_nxt;

    assign wr_ok  = reg_wr && !cfg_lock;
    assign wr_fmt = wr_ok && (reg_addr == TPC_ADDR_FMT_CFG);
    assign wr_pin = wr_ok && (reg_addr == TPC_ADDR_PIN_CFG);

    assign fmt_cfg_nxt = wr_fmt ? (reg_wdata & TPC_MASK_FMT_CFG) : fmt_cfg_r;
    assign pin_cfg_nxt = wr_pin ? (reg_wdata & TPC_MASK_PIN_CFG) : pin_cfg_r;

    // Configuration storage.
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            fmt_cfg_r <= TPC_RST_FMT_CFG;
            pin_cfg_r <= TPC_RST_PIN_CFG;
        end else begin
            fmt_cfg_r <= fmt_cfg_nxt;
            pin_cfg_r <= pin_cfg_nxt;
        end
    end

    // ************************************************************
    // Read path
    // ************************************************************
    wire logic [7:0] rdata_nxt;

    assign rdata_nxt =
        (reg_addr == TPC_ADDR_FMT_CFG) ? fmt_cfg_r :
        (reg_addr == TPC_ADDR_PIN_CFG) ? pin_cfg_r :
        ((reg_addr == TPC_ADDR_TEST_A) ||
         (reg_addr == TPC_ADDR_TEST_B)) ? TPC_TEST_VALUE :
        TPC_READ_UNMAP;

    // Read data is captured on the read strobe and then held.
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            rdata_r <= TPC_READ_UNMAP;
        end else if (reg_rd) begin
            rdata_r <= rdata_nxt;
        end
    end

    assign reg_rdata = rdata_r;

    // ************************************************************
    // Field decode
    // ************************************************************
    wire logic           fmt_signed;
    wire logic [NCH-1:0] chan_en;
    wire logic [1:0]     pin_func;
    wire logic           alarm_dis;
    wire logic           speed_sel;

    assign fmt_signed = fmt_cfg_r[TPC_BIT_SIGNED_FMT];
    assign chan_en    = fmt_cfg_r[TPC_BIT_EN_HI:TPC_BIT_EN_LO];
    assign pin_func   = pin_cfg_r[TPC_BIT_FUNC_HI:TPC_BIT_FUNC_LO];
    assign alarm_dis  = pin_cfg_r[TPC_BIT_ALARM_DIS];
    assign speed_sel  = pin_cfg_r[TPC_BIT_SPEED_SEL];

    assign signed_temperature_format = fmt_signed;

    assign core_voltage_attenuator_bypass = pin_cfg_r[TPC_BIT_ATTEN_BYPASS];

    assign shared_pin_role[TPC_FUNC_FAN4_TACH_INPUT] = (pin_func == TPC_FUNC_FAN4_TACH_INPUT);
    assign shared_pin_role[TPC_FUNC_ALARM] = (pin_func == TPC_FUNC_ALARM);
    assign shared_pin_role[TPC_FUNC_ALERT] = (pin_func == TPC_FUNC_ALERT);
    assign shared_pin_role[TPC_FUNC_GPIO]  = (pin_func == TPC_FUNC_GPIO);

    // ************************************************************
    // Channel comparison
    // ************************************************************
    logic [NCH-1:0] chan_over;
    logic [NCH-1:0] chan_off;

    // One comparator per temperature channel.
    genvar gi;
    generate
        for (gi = 0; gi < NCH; gi++) begin : g_chan
            tpc_limit_cmp u_cmp (
                .fmt_signed (fmt_signed),
                .temp       (chan_temp[gi]),
                .limit      (chan_limit[gi]),
                .over       (chan_over[gi]),
                .limit_off  (chan_off[gi])
            );
        end
    endgenerate

    // ************************************************************
    // Alarm and fan override
    // ************************************************************
    wire logic                 alarm_nxt;
    logic [NFAN-1:0][7:0]      duty_nxt;

    assign alarm_nxt = !alarm_dis && |(chan_over & chan_en);

    always_comb begin
        for (int i = 0; i < NFAN; i++) begin
            duty_nxt[i] = speed_sel ? fan_max_duty[i] : TPC_DUTY_FULL;
        end
    end

    // Alarm state and override duties.
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            alarm_r   <= 1'b0;
            fan_ovr_r <= 1'b0;
            duty_r    <= '0;
        end else begin
            alarm_r   <= alarm_nxt;
            fan_ovr_r <= alarm_nxt;
            duty_r    <= duty_nxt;
        end
    end

    assign fan_override      = fan_ovr_r;
    assign fan_override_duty = duty_r;

    // The pin is pulled low only while an enabled channel is over.
    assign thermal_alarm_pin_out = 1'b0;
    assign thermal_alarm_pin_oe  = alarm_r;
    assign shared_pin_out        = 1'b0;
    assign shared_pin_oe         = alarm_r && shared_pin_role[TPC_FUNC_ALARM];

    // ************************************************************
    // Timer input synchroniser
    // ************************************************************

    // Two flops before the pin level reaches the assertion timer.
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            pin_meta_r <= 1'b1;
            pin_sync_r <= 1'b1;
        end else begin
            pin_meta_r <= thermal_alarm_pin_in;
            pin_sync_r <= pin_meta_r;
        end
    end

    // Timer sees the asserted (low) pin as a high level.
    assign alarm_timer_in = !pin_sync_r;

    // ************************************************************
    // Checks
    // ************************************************************
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (rst);

    sequence s_locked_write;
        reg_wr && cfg_lock;
    endsequence

    sequence s_regs_hold;
        $stable(fmt_cfg_r) && $stable(pin_cfg_r);
    endsequence

    chk_lock_write_block: assert property (
        s_locked_write |=> s_regs_hold)
        else $error("Locked write changed a configuration register.");

    chk_test_read_zero: assert property (
        reg_rd && (reg_addr[7:1] == TPC_ADDR_TEST_A[7:1])
        |=> reg_rdata == TPC_TEST_VALUE)
        else $error("Test register did not read zero.");

    chk_reserved_read_zero: assert property (
        reg_rd && (reg_addr == TPC_ADDR_PIN_CFG)
        |=> (reg_rdata & ~TPC_MASK_PIN_CFG) == 8'h00)
        else $error("Reserved bit read back as one.");

    chk_disable_no_drive: assert property (
        alarm_dis |=> !thermal_alarm_pin_oe)
        else $error("Alarm pin driven while feature disabled.");

    chk_local_pin_drive: assert property (
        !alarm_dis && chan_en[1] && chan_over[1] |=> thermal_alarm_pin_oe)
        else $error("Local over-limit did not drive the alarm pin.");

    chk_remote2_pin_drive: assert property (
        !alarm_dis && chan_en[2] && chan_over[2] |=> thermal_alarm_pin_oe)
        else $error("Remote-2 over-limit did not drive the alarm pin.");

    chk_remote1_pin_drive: assert property (
        !alarm_dis && chan_en[0] && chan_over[0] |=> thermal_alarm_pin_oe)
        else $error("Remote-1 over-limit did not drive the alarm pin.");

    chk_off64_limit_off: assert property (
        !fmt_signed && chan_limit[0] == TPC_LIM_OFF_OFF64 |-> !chan_over[0])
        else $error("Offset-64 off code still raised the alarm.");

    chk_signed_limit_off: assert property (
        fmt_signed && chan_limit[0] == TPC_LIM_OFF_SIGNED |-> !chan_over[0])
        else $error("Signed off code still raised the alarm.");

    chk_full_speed_duty: assert property (
        alarm_nxt && !speed_sel
        |=> fan_override && fan_override_duty[0] == TPC_DUTY_FULL)
        else $error("Fans not at full duty on alarm.");

    chk_max_speed_duty: assert property (
        alarm_nxt && speed_sel
        |=> fan_override && fan_override_duty[0] == $past(fan_max_duty[0]))
        else $error("Fans not at programmed maximum on alarm.");

    chk_pin_role_map: assert property (
        wr_pin && reg_wdata[1:0] == TPC_FUNC_ALARM
        |=> shared_pin_role == 4'h2)
        else $error("Shared pin role does not follow its field.");

endmodule

/* File: verification/tpc_host_model.sv */
// Purpose: Register host standing in for the serial engine.
// Assumes: Requests launch just after a falling edge of ref_clk.
// Notes:   Idle address and data lines are inverted so stale values show.
`timescale 1ns/1ps
module tpc_host_model
    import tpc_pkg::*;
(
    // Clock
    input  wire logic       ref_clk,
    // Register access
    output logic [7:0]      reg_addr,
    output logic [7:0]      reg_wdata,
    output logic            reg_wr,
    output logic            reg_rd,
    input  wire logic [7:0] reg_rdata
);
    // ************************************************************
    // Access tasks
    // ************************************************************
    // Lines start idle with a pattern the design must ignore.
    initial begin
        reg_addr  = 8'ha5;
        reg_wdata = 8'h5a;
        reg_wr    = 1'b0;
        reg_rd    = 1'b0;
    end

    // test writes only when commanded.
    // One write strobe for one cycle, then the lines are scrambled.
    task automatic write_reg(input logic [7:0] addr,
                             input logic [7:0] data);
        @(negedge ref_clk);
        reg_addr  = addr;
        reg_wdata = data;
        reg_wr    = 1'b1;
        @(negedge ref_clk);
        reg_wr    = 1'b0;
        reg_addr  = ~addr;
        reg_wdata = ~data;
    endtask

    // One read strobe; data is taken a cycle and a half after the read edge.
    task automatic read_reg(input logic [7:0] addr, output logic [7:0] data);
        @(negedge ref_clk);
        reg_addr = addr;
        reg_rd   = 1'b1;
        @(negedge ref_clk);
        reg_rd   = 1'b0;
        reg_addr = ~addr;
        @(negedge ref_clk);
        data = reg_rdata;
    endtask
endmodule

/* File: verification/test_tpc_config_regs.sv */
// Purpose: Self-checking bench for the pin and alarm configuration bank.
// Assumes: Inputs change on the falling edge of a 20 MHz clock.
// Notes:   Channel index 0 is remote 1, 1 is local, 2 is remote 2.
`timescale 1ns/1ps
module test_tpc_config_regs
    import tpc_pkg::*;
;
    // ************************************************************
    // Signals and instances
    // ************************************************************
    logic            ref_clk;
    logic            rst;
    logic            cfg_lock;
    logic            ext_low;
    logic [7:0]      reg_addr;
    logic [7:0]      reg_wdata;
    logic [7:0]      reg_rdata;
    logic            reg_wr;
    logic            reg_rd;
    logic [2:0][7:0] chan_temp;
    logic [2:0][7:0] chan_limit;
    logic [2:0][7:0] fan_max_duty;
    logic [2:0][7:0] ovr_duty;
    logic            pin_in;
    logic            pin_out;
    logic            pin_oe;
    logic            timer_in;
    logic            sh_out;
    logic            sh_oe;
    logic [3:0]      role;
    logic            fan_ovr;
    logic            fmt;
    logic            byp;
    int              mismatches;
    int              n_tests;
    int              cycles;

    // The open-drain wire is low if the design or the far side pulls it.
    assign pin_in = (pin_oe && !pin_out) ? 1'b0 : !ext_low;

    tpc_config_regs #(.NCH(3), .NFAN(3)) tpc_config_regs_inst (
        .ref_clk(ref_clk), .rst(rst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .cfg_lock(cfg_lock),
        .chan_temp(chan_temp), .chan_limit(chan_limit),
        .fan_max_duty(fan_max_duty), .thermal_alarm_pin_in(pin_in),
        .thermal_alarm_pin_out(pin_out), .thermal_alarm_pin_oe(pin_oe),
        .alarm_timer_in(timer_in), .shared_pin_out(sh_out),
        .shared_pin_oe(sh_oe), .shared_pin_role(role),
        .fan_override(fan_ovr), .fan_override_duty(ovr_duty),
        .signed_temperature_format(fmt),
        .core_voltage_attenuator_bypass(byp)
    );

    tpc_host_model tpc_host_model_inst (
        .ref_clk(ref_clk), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata)
    );

    // ************************************************************
    // Helper tasks
    // ************************************************************
    // Compares one value and counts the comparison.
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        n_tests++;
        if (got !== exp) begin
            mismatches++;
            $display("Error at %0t ns: got %h expected %h", $time, got, exp);
        end
    endtask

    // Reads a register and compares the byte returned.
    task automatic rd_chk(input logic [7:0] addr, input logic [7:0] exp);
        logic [7:0] d;
        tpc_host_model_inst.read_reg(addr, d);
        check(d, exp);
    endtask

    // Writes one register through the host model.
    task automatic wr(input logic [7:0] addr, input logic [7:0] data);
        tpc_host_model_inst.write_reg(addr, data);
    endtask

    // Sets one channel's temperature and limit on a falling edge.
    task automatic set_ch(input int i, input logic [7:0] t,
                          input logic [7:0] l);
        @(negedge ref_clk);
        chan_temp[i]  = t;
        chan_limit[i] = l;
    endtask

    // Lets the alarm settle, then checks pin, override and duties.
    task automatic alarm_chk(input logic on, input logic full);
        repeat (2) @(negedge ref_clk);
        check({7'h00, pin_oe}, {7'h00, on});
        check({7'h00, fan_ovr}, {7'h00, on});
        // Both open-drain drives only ever pull low.
        check({6'h00, pin_out, sh_out}, 8'h00);
        for (int f = 0; f < 3 && on; f++) begin
            check(ovr_duty[f], full ? 8'hff : fan_max_duty[f]);
        end
    endtask

    // Prints the verdict and ends the run.
    task automatic complete_run;
        if (mismatches == 0 && n_tests > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // ************************************************************
    // Clock, timeout and test sequence
    // ************************************************************
    // Free-running 50 ns clock.
    always #25 ref_clk = ~ref_clk;

    // Cuts a hang short well beyond the expected run of under 200 cycles.
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 3000) begin
            mismatches++;
            complete_run();
        end
    end

    // Main sequence of register and alarm scenarios.
    initial begin
        ref_clk = 1'b0; rst = 1'b1; cfg_lock = 1'b0; ext_low = 1'b0;
        chan_temp = '0; chan_limit = '0; cycles = 0;
        fan_max_duty = {8'h33, 8'h22, 8'h11};
        mismatches = 0; n_tests = 0;
        repeat (2) @(negedge ref_clk);
        rst = 1'b0;
        rd_chk(TPC_ADDR_FMT_CFG, 8'h00);
        rd_chk(TPC_ADDR_PIN_CFG, 8'h00);
        rd_chk(TPC_ADDR_TEST_A, 8'h00);
        rd_chk(TPC_ADDR_TEST_B, 8'h00);
        rd_chk(8'h10, 8'h00);
        check({4'h0, role}, 8'h01);
        // Reserved bits and test registers must not take writes.
        wr(TPC_ADDR_FMT_CFG, 8'hff);
        rd_chk(TPC_ADDR_FMT_CFG, 8'hef);
        check({7'h00, fmt}, 8'h01);
        wr(TPC_ADDR_PIN_CFG, 8'hff);
        rd_chk(TPC_ADDR_PIN_CFG, 8'h4f);
        check({7'h00, byp}, 8'h01);
        wr(TPC_ADDR_TEST_A, 8'h5a);
        wr(TPC_ADDR_TEST_B, 8'ha5);
        rd_chk(TPC_ADDR_TEST_A, 8'h00);
        rd_chk(TPC_ADDR_TEST_B, 8'h00);
        // Every shared pin role code.
        for (int c = 0; c < 4; c++) begin
            wr(TPC_ADDR_PIN_CFG, 8'(c));
            check({4'h0, role}, 8'(1 << c));
        end
        check({7'h00, byp}, 8'h00);
        // Each channel alarms only when its own enable is set.
        wr(TPC_ADDR_PIN_CFG, 8'h01);
        for (int i = 0; i < 3; i++) begin
            wr(TPC_ADDR_FMT_CFG, 8'h00);
            set_ch(i, 8'h90, 8'h80);
            alarm_chk(1'b0, 1'b1);
            wr(TPC_ADDR_FMT_CFG, 8'(8'h20 << i));
            alarm_chk(1'b1, 1'b1);
            check({7'h00, sh_oe}, 8'h01);
            set_ch(i, 8'h00, 8'h80);
        end
        // Speed select, feature disable and the off limits.
        set_ch(1, 8'h90, 8'h80);
        wr(TPC_ADDR_FMT_CFG, 8'h40);
        wr(TPC_ADDR_PIN_CFG, 8'h09);
        alarm_chk(1'b1, 1'b0);
        wr(TPC_ADDR_PIN_CFG, 8'h05);
        alarm_chk(1'b0, 1'b1);
        check({7'h00, sh_oe}, 8'h00);
        wr(TPC_ADDR_PIN_CFG, 8'h01);
        set_ch(1, 8'h90, TPC_LIM_OFF_OFF64);
        alarm_chk(1'b0, 1'b1);
        wr(TPC_ADDR_FMT_CFG, 8'h41);
        set_ch(1, 8'h10, 8'hf0);
        alarm_chk(1'b1, 1'b1);
        // The alarm stays off the shared pin unless its role is alarm.
        wr(TPC_ADDR_PIN_CFG, 8'h02);
        alarm_chk(1'b1, 1'b1);
        check({7'h00, sh_oe}, 8'h00);
        wr(TPC_ADDR_PIN_CFG, 8'h01);
        set_ch(1, 8'h10, TPC_LIM_OFF_SIGNED);
        alarm_chk(1'b0, 1'b1);
        // Lock freezes both registers until it is lifted.
        cfg_lock = 1'b1;
        wr(TPC_ADDR_PIN_CFG, 8'h4a);
        wr(TPC_ADDR_FMT_CFG, 8'h00);
        rd_chk(TPC_ADDR_PIN_CFG, 8'h01);
        rd_chk(TPC_ADDR_FMT_CFG, 8'h41);
        cfg_lock = 1'b0;
        wr(TPC_ADDR_PIN_CFG, 8'h4a);
        rd_chk(TPC_ADDR_PIN_CFG, 8'h4a);
        // A second reset in mid-run brings both registers back to default.
        rst = 1'b1;
        @(negedge ref_clk);
        rst = 1'b0;
        rd_chk(TPC_ADDR_PIN_CFG, TPC_RST_PIN_CFG);
        rd_chk(TPC_ADDR_FMT_CFG, TPC_RST_FMT_CFG);
        check({4'h0, role}, 8'h01);
        check({7'h00, pin_oe}, 8'h00);
        // Far side pulls the pin; the timer input follows it.
        ext_low = 1'b1;
        repeat (3) @(negedge ref_clk);
        check({7'h00, timer_in}, 8'h01);
        ext_low = 1'b0;
        repeat (3) @(negedge ref_clk);
        check({7'h00, timer_in}, 8'h00);
        complete_run();
    end
endmodule
